//--- rss_exec_cfg.svh
// Constants for the rotate, sleep and subtract execution block
`ifndef RSS_EXEC_CFG_SVH
`define RSS_EXEC_CFG_SVH
// Opcode fields, upper six bits of the instruction word
`define OPC_ROTATE_LEFT   6'h0D
`define OPC_ROTATE_RIGHT  6'h0C
// Upper five bits of the literal subtract, bit 8 is don't-care
`define OPC_LIT_SUB       5'h1E
// Fixed sleep pattern
`define OPC_SLEEP         14'h0063
// Field positions
`define DEST_BIT          7
// Reset values
`define ACC_RESET         8'h00
`define WDOG_RESET        8'h00
`define PRESC_RESET       8'h00
`endif

//--- rss_exec_pkg.sv
// Types for the rotate, sleep and subtract execution block
`default_nettype none
package rss_exec_pkg;
    // Instruction phases, one instruction cycle
    typedef enum logic [1:0] {
        PH_DECODE  = 2'b00,
        PH_READ    = 2'b01,
        PH_PROCESS = 2'b10,
        PH_WRITE   = 2'b11
    } phase_type;
    // Decoded operation
    typedef enum logic [2:0] {
        OP_NONE  = 3'b000,
        OP_RLEFT = 3'b001,
        OP_RRIGHT= 3'b010,
        OP_SLEEP = 3'b011,
        OP_LSUB  = 3'b100
    } op_type;
    // Status flags carried together
    typedef struct packed {
        logic carry;
        logic digitCarry;
        logic zero;
        logic timeExpired;
        logic powerDown;
    } flags_type;
    // File register write request
    typedef struct packed {
        logic       en;
        logic [6:0] addr;
        logic [7:0] data;
    } fwrite_type;
endpackage
`default_nettype wire

//--- rotate_sleep_subtract_exec.sv
// Execute logic for rotate, sleep and literal subtract instructions
`timescale 1ns/1ns
`default_nettype none
`include "rss_exec_cfg.svh"

// How it works
// - Rotate left: carry into bit 0, bit 7 out
// - Destination bit: 0 accumulator, 1 file
// - Fixed pattern 0x0063 decodes as sleep
// - Sleep clears power-down flag
// - Sleep sets time-expired flag
// - Sleep clears watchdog count and prescaler
// - Sleep entered in fourth phase, oscillator stops
// - Literal subtract from upper bits 11110x
// - Compute literal minus accumulator, two's complement
// - Difference replaces accumulator
// - Subtract updates carry, digit carry, zero
// - Carry set when result non-negative
module rotate_sleep_subtract_exec (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    // Instruction and file operand, sampled in decode and read
    input  wire logic [13:0]              instr,
    input  wire logic [7:0]               fileRdData,
    // Wake request from outside, ends sleep after synchronising
    input  wire logic                     wakeUp,
    // File register address and write request
    output logic [6:0]                    fileRdAddr,
    output rss_exec_pkg::fwrite_type      fileWr,
    // Architectural state
    output logic [7:0]                    accum,
    output rss_exec_pkg::flags_type       flags,
    output logic [7:0]                    watchdogCount,
    output logic [7:0]                    watchdogPrescaler,
    output logic                          sleeping,
    output logic                          oscRun
);
    // Phase counter and decoded operation
    rss_exec_pkg::phase_type phase_q;
    rss_exec_pkg::op_type    op_q;
    logic [13:0]             instr_q;   // Latched instruction
    logic [7:0]              operand_q; // File or literal operand
    logic [8:0]              result_q;  // Result plus carry out
    logic                    dc_q;      // Digit carry of subtract
    logic [7:0]              acc_q;
    logic [7:0]              wdog_q;
    logic [7:0]              presc_q;
    rss_exec_pkg::flags_type flags_q;
    rss_exec_pkg::fwrite_type fwr_q;
    logic                    sleep_q;
    logic                    oscRun_q;  // Oscillator running, own flop
    logic                    wakeSync1_q;
    logic                    wakeSync2_q;

    // Decode the instruction word
    function automatic rss_exec_pkg::op_type decodeOp(input logic [13:0] w);
        if (w == `OPC_SLEEP)
            decodeOp = rss_exec_pkg::OP_SLEEP;
        else if (w[13:8] == `OPC_ROTATE_LEFT)
            decodeOp = rss_exec_pkg::OP_RLEFT;
        else if (w[13:8] == `OPC_ROTATE_RIGHT)
            decodeOp = rss_exec_pkg::OP_RRIGHT;
        else if (w[13:9] == `OPC_LIT_SUB)
            decodeOp = rss_exec_pkg::OP_LSUB;
        else
            decodeOp = rss_exec_pkg::OP_NONE;
    endfunction

    // Wake request from outside passes a two-stage synchroniser
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wakeSync1_q <= 1'b0;
            wakeSync2_q <= 1'b0;
        end else begin
            wakeSync1_q <= wakeUp;
            wakeSync2_q <= wakeSync1_q;
        end
    end

    // Phase sequencer, held while asleep
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= rss_exec_pkg::PH_DECODE;
        end else if (!sleep_q) begin
            phase_q <= rss_exec_pkg::phase_type'(phase_q + 2'b01);
        end
    end

    // Decode in first phase, operand in second, compute in third
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op_q      <= rss_exec_pkg::OP_NONE;
            instr_q   <= 14'h0000;
            operand_q <= 8'h00;
            result_q  <= 9'h000;
            dc_q      <= 1'b0;
        end else if (!sleep_q) begin
            case (phase_q)
                rss_exec_pkg::PH_DECODE: begin
                    op_q    <= decodeOp(instr);
                    instr_q <= instr;
                end
                rss_exec_pkg::PH_READ: begin
                    // Literal for subtract, file data otherwise
                    if (op_q == rss_exec_pkg::OP_LSUB)
                        operand_q <= instr_q[7:0];
                    else
                        operand_q <= fileRdData;
                end
                rss_exec_pkg::PH_PROCESS: begin
                    case (op_q)
                        rss_exec_pkg::OP_RLEFT:
                            result_q <= {operand_q,
                                         flags_q.carry};
                        rss_exec_pkg::OP_RRIGHT:
                            result_q <= {operand_q[0], flags_q.carry,
                                         operand_q[7:1]};
                        rss_exec_pkg::OP_LSUB: begin
                            // Add the complement plus one; bit 8 is
                            // the inverted borrow
                            result_q <= {1'b0, operand_q}
                                      + {1'b0, ~acc_q} + 9'h001;
                            dc_q <= ({1'b0, operand_q[3:0]}
                                   + {1'b0, ~acc_q[3:0]}
                                   + 5'h01) > 5'h0F;
                        end
                        default: result_q <= result_q;
                    endcase
                end
                default: ;
            endcase
        end
    end

    // Write destination and flags in the fourth phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q   <= `ACC_RESET;
            fwr_q   <= '0;
            flags_q <= '{carry: 1'b0, digitCarry: 1'b0, zero: 1'b0,
                         timeExpired: 1'b1, powerDown: 1'b1};
        end else begin
            fwr_q.en <= 1'b0;
            if (!sleep_q && phase_q == rss_exec_pkg::PH_WRITE) begin
                case (op_q)
                    rss_exec_pkg::OP_RLEFT,
                    rss_exec_pkg::OP_RRIGHT: begin
                        flags_q.carry <= result_q[8];
                        if (instr_q[`DEST_BIT]) begin
                            fwr_q.en   <= 1'b1;
                            fwr_q.addr <= instr_q[6:0];
                            fwr_q.data <= result_q[7:0];
                        end else begin
                            acc_q <= result_q[7:0];
                        end
                    end
                    rss_exec_pkg::OP_LSUB: begin
                        acc_q              <= result_q[7:0];
                        flags_q.carry      <= result_q[8];
                        flags_q.digitCarry <= dc_q;
                        flags_q.zero       <= result_q[7:0] == 8'h00;
                    end
                    rss_exec_pkg::OP_SLEEP: begin
                        flags_q.powerDown   <= 1'b0;
                        flags_q.timeExpired <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    // Watchdog count and prescaler: free count, cleared by sleep
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdog_q  <= `WDOG_RESET;
            presc_q <= `PRESC_RESET;
        end else if (!sleep_q && phase_q == rss_exec_pkg::PH_WRITE
                     && op_q == rss_exec_pkg::OP_SLEEP) begin
            wdog_q  <= 8'h00;
            presc_q <= 8'h00;
        end else begin
            presc_q <= presc_q + 8'h01;
            if (presc_q == 8'hFF)
                wdog_q <= wdog_q + 8'h01;
        end
    end

    // Sleep state: entered in fourth phase, left on wake request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_q  <= 1'b0;
            oscRun_q <= 1'b1;
        end else if (sleep_q) begin
            // Wake request restarts the oscillator
            if (wakeSync2_q) begin
                sleep_q  <= 1'b0;
                oscRun_q <= 1'b1;
            end
        end else if (phase_q == rss_exec_pkg::PH_WRITE
                     && op_q == rss_exec_pkg::OP_SLEEP) begin
            sleep_q  <= 1'b1;
            oscRun_q <= 1'b0;
        end
    end

    // Outputs straight from flip-flops
    assign fileRdAddr        = instr_q[6:0];
    assign fileWr            = fwr_q;
    assign accum             = acc_q;
    assign flags             = flags_q;
    assign watchdogCount     = wdog_q;
    assign watchdogPrescaler = presc_q;
    assign sleeping          = sleep_q;
    assign oscRun            = oscRun_q;

    // Checks
    chk_sleep_entry: assert property (@(posedge clk) disable iff (!rst_n)
        (!sleep_q && phase_q == rss_exec_pkg::PH_WRITE
         && op_q == rss_exec_pkg::OP_SLEEP)
        |=> sleep_q && !oscRun && wdog_q == 8'h00
            && presc_q == 8'h00)
        else $error("sleep not entered");
    chk_sleep_flags: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(sleep_q) |-> !flags_q.powerDown && flags_q.timeExpired)
        else $error("sleep flags wrong");
    chk_sub_result: assert property (@(posedge clk) disable iff (!rst_n)
        (!sleep_q && phase_q == rss_exec_pkg::PH_WRITE
         && op_q == rss_exec_pkg::OP_LSUB)
        |=> acc_q == 8'(operand_q - $past(acc_q)))
        else $error("subtract result wrong");
    chk_sub_carry: assert property (@(posedge clk) disable iff (!rst_n)
        (!sleep_q && phase_q == rss_exec_pkg::PH_WRITE
         && op_q == rss_exec_pkg::OP_LSUB)
        |=> flags_q.carry == (operand_q >= $past(acc_q)))
        else $error("subtract carry wrong");
    chk_sub_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (!sleep_q && phase_q == rss_exec_pkg::PH_WRITE
         && op_q == rss_exec_pkg::OP_LSUB)
        |=> flags_q.zero == (operand_q == $past(acc_q)))
        else $error("zero flag wrong");
    chk_sub_digit: assert property (@(posedge clk) disable iff (!rst_n)
        (!sleep_q && phase_q == rss_exec_pkg::PH_WRITE
         && op_q == rss_exec_pkg::OP_LSUB)
        |=> flags_q.digitCarry
            == ({4'h0, operand_q[3:0]} >= ($past(acc_q) & 8'h0F)))
        else $error("digit carry wrong");
    chk_rotl_value: assert property (@(posedge clk) disable iff (!rst_n)
        (!sleep_q && phase_q == rss_exec_pkg::PH_WRITE
         && op_q == rss_exec_pkg::OP_RLEFT && !instr_q[`DEST_BIT])
        |=> acc_q == {operand_q[6:0], $past(flags_q.carry)}
            && flags_q.carry == operand_q[7])
        else $error("rotate left wrong");
    chk_rotr_value: assert property (@(posedge clk) disable iff (!rst_n)
        (!sleep_q && phase_q == rss_exec_pkg::PH_WRITE
         && op_q == rss_exec_pkg::OP_RRIGHT && !instr_q[`DEST_BIT])
        |=> acc_q == {$past(flags_q.carry), operand_q[7:1]}
            && flags_q.carry == operand_q[0])
        else $error("rotate right wrong");
    chk_rot_dest: assert property (@(posedge clk) disable iff (!rst_n)
        (!sleep_q && phase_q == rss_exec_pkg::PH_WRITE
         && (op_q == rss_exec_pkg::OP_RLEFT
             || op_q == rss_exec_pkg::OP_RRIGHT))
        |=> fwr_q.en == $past(instr_q[`DEST_BIT])
            && (!fwr_q.en || fwr_q.addr == instr_q[6:0]))
        else $error("rotate destination wrong");
    chk_phase_cycle: assert property (@(posedge clk) disable iff (!rst_n)
        (phase_q == rss_exec_pkg::PH_DECODE && !sleep_q)
        |-> ##3 phase_q == rss_exec_pkg::PH_WRITE)
        else $error("phase cycle wrong");
    chk_sleep_decode: assert property (@(posedge clk) disable iff (!rst_n)
        (!sleep_q && phase_q == rss_exec_pkg::PH_DECODE
         && instr == `OPC_SLEEP)
        |=> op_q == rss_exec_pkg::OP_SLEEP)
        else $error("sleep decode wrong");
    chk_sub_decode: assert property (@(posedge clk) disable iff (!rst_n)
        (!sleep_q && phase_q == rss_exec_pkg::PH_DECODE
         && instr[13:9] == `OPC_LIT_SUB)
        |=> op_q == rss_exec_pkg::OP_LSUB)
        else $error("subtract decode wrong");
endmodule // rotate_sleep_subtract_exec
`default_nettype wire

//--- rotate_sleep_subtract_exec_bench.sv
// Self-checking bench for the rotate, sleep and subtract block
`timescale 1ns/1ns
`default_nettype none
module rotate_sleep_subtract_exec_bench;
    // Stimulus
    logic                     clk;
    logic                     rst_n;
    logic [13:0]              instr;
    logic [7:0]               fileRdData;
    logic                     wakeUp;
    // Outputs
    logic [6:0]               fileRdAddr;
    rss_exec_pkg::fwrite_type fileWr;
    logic [7:0]               accum;
    rss_exec_pkg::flags_type  flags;
    logic [7:0]               watchdogCount;
    logic [7:0]               watchdogPrescaler;
    logic                     sleeping;
    logic                     oscRun;
    // Bench model state
    logic [7:0]               mAcc;
    rss_exec_pkg::flags_type  mFlags;
    rss_exec_pkg::fwrite_type mWr;
    logic                     mSleep;
    logic                     mNewSleep;
    logic                     pend;
    logic [6:0]               mAddr;
    int                       err_count;
    int                       checks_done;

    rotate_sleep_subtract_exec rotate_sleep_subtract_exec_i (
        .clk(clk), .rst_n(rst_n), .instr(instr), .fileRdData(fileRdData),
        .wakeUp(wakeUp), .fileRdAddr(fileRdAddr), .fileWr(fileWr),
        .accum(accum), .flags(flags), .watchdogCount(watchdogCount),
        .watchdogPrescaler(watchdogPrescaler), .sleeping(sleeping),
        .oscRun(oscRun)
    );

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Verdict and end of run
    task automatic results();
        if (err_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Mismatch report
    task automatic fail(input string msg);
        err_count++;
        $display("[ERR] %0t %s", $time, msg);
    endtask

    // Compare tasks, one per kind of result
    task automatic cmpByte(input logic [7:0] g, e, input string w);
        checks_done++;
        if (g !== e) fail(w);
    endtask
    task automatic cmpBit(input logic g, e, input string w);
        checks_done++;
        if (g !== e) fail(w);
    endtask
    task automatic cmpFlags(input rss_exec_pkg::flags_type g, e);
        checks_done++;
        if (g !== e) fail("status flags");
    endtask
    task automatic cmpWrite(input rss_exec_pkg::fwrite_type g, e);
        checks_done++;
        // Address and data only matter while the strobe is up
        if (g.en !== e.en || (e.en === 1'b1 && g !== e)) fail("file write");
    endtask

    // Compare the outcome of the last instruction, mid-cycle
    task automatic settle();
        @(negedge clk);
        if (pend) begin
            cmpByte(accum, mAcc, "accumulator");
            cmpFlags(flags, mFlags);
            cmpWrite(fileWr, mWr);
            cmpBit(sleeping, mSleep, "sleep state");
            cmpBit(oscRun, ~mSleep, "oscillator");
            cmpByte({1'b0, fileRdAddr}, {1'b0, mAddr}, "address");
            if (mNewSleep) begin
                cmpByte(watchdogCount, 8'h00, "watchdog");
                cmpByte(watchdogPrescaler, 8'h00, "prescaler");
            end
        end
        pend = 1'b0;
    endtask

    // Work out the expected effect of one instruction
    task automatic predict(input logic [13:0] i, input logic [7:0] f);
        logic [7:0] res;
        mWr = '0;
        mNewSleep = 1'b0;
        if (!mSleep) mAddr = i[6:0];
        if (mSleep) begin
            // Asleep: instruction ignored
        end else if (i[13:9] == 5'h06) begin
            // Bit 8 picks left (1) or right (0)
            res = i[8] ? {f[6:0], mFlags.carry} : {mFlags.carry, f[7:1]};
            mFlags.carry = i[8] ? f[7] : f[0];
            if (i[7]) mWr = {1'b1, i[6:0], res};
            else mAcc = res;
        end else if (i[13:9] == 5'h1E) begin
            res = i[7:0] - mAcc;
            mFlags.carry = (i[7:0] >= mAcc);
            mFlags.digitCarry = (i[3:0] >= mAcc[3:0]);
            mFlags.zero = (res == 8'h00);
            mAcc = res;
        end else if (i == 14'h0063) begin
            mSleep = 1'b1;
            mNewSleep = 1'b1;
            mFlags.powerDown = 1'b0;
            mFlags.timeExpired = 1'b1;
        end
        pend = 1'b1;
    endtask

    // One full instruction cycle, checking the previous one
    task automatic run(input logic [13:0] i, input logic [7:0] f);
        instr <= i;
        fileRdData <= f;
        settle();
        predict(i, f);
        repeat (4) @(posedge clk);
    endtask

    // Reset for 21 cycles, checking values held in reset
    task automatic doReset();
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        @(negedge clk);
        cmpByte(accum, 8'h00, "reset accumulator");
        cmpFlags(flags, 5'h03);
        cmpBit(fileWr.en, 1'b0, "reset write");
        cmpBit(oscRun, 1'b1, "reset oscillator");
        cmpBit(sleeping, 1'b0, "reset sleep");
        cmpByte(watchdogCount, 8'h00, "reset watchdog");
        cmpByte(watchdogPrescaler, 8'h00, "reset prescaler");
        @(posedge clk);
        rst_n <= 1'b1;
        mAcc = 8'h00;
        mFlags = 5'h03;
        mSleep = 1'b0;
        mAddr = 7'h00;
        pend = 1'b0;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        fail("timeout");
        results();
    end

    // Main sequence
    initial begin
        logic [13:0] r;
        int          n;
        rst_n = 1'b0;
        instr = 14'h0000;
        fileRdData = 8'h00;
        wakeUp = 1'b0;
        err_count = 0;
        checks_done = 0;
        void'($urandom(26));
        doReset();
        // Subtract corners: positive, zero, negative
        run(14'h3C02, 8'h00);
        run(14'h3D02, 8'h00);
        run(14'h3C03, 8'h00);
        run(14'h3D02, 8'h00);
        // Rotates to each destination
        run(14'h0D26, 8'hE6);
        run(14'h0CFF, 8'h01);
        // Near misses of the sleep pattern do nothing
        run(14'h0062, 8'h55);
        run(14'h0064, 8'h55);
        // Random instructions back to back
        for (n = 0; n < 60; n++) begin
            r = 14'($urandom);
            case ($urandom_range(0, 3))
                0: r[13:8] = 6'h0D;
                1: r[13:8] = 6'h0C;
                2: r[13:9] = 5'h1E;
                default: if (r[13:9] == 5'h1E || r[13:9] == 5'h06
                             || r == 14'h0063) r = 14'h0000;
            endcase
            run(r, 8'($urandom));
        end
        // Sleep, then an instruction that must be ignored
        run(14'h0063, 8'h00);
        run(14'h3CAA, 8'h00);
        settle();
        // Wake and reset mid-run
        @(posedge clk);
        wakeUp <= 1'b1;
        n = 0;
        while (sleeping !== 1'b0 && n < 10) begin
            @(negedge clk);
            n++;
        end
        if (n == 10) fail("no wake");
        @(posedge clk);
        wakeUp <= 1'b0;
        doReset();
        run(14'h3C05, 8'h00);
        settle();
        results();
    end
endmodule // rotate_sleep_subtract_exec_bench
`default_nettype wire
